/* File: hw/ciu_pkg.sv */
// condition indicator unit: constants shared by the design and the bench
// assumes a 50 MHz processor clock and an AXI4-Lite register master
`default_nettype none
package ciu_pkg;
  // level status word bit positions, index equals printed bit number
  localparam int unsigned LSW_EVEN = 0;
  localparam int unsigned LSW_CARRY = 1;
  localparam int unsigned LSW_OVFL = 2;
  localparam int unsigned LSW_NEG = 3;
  localparam int unsigned LSW_ZERO = 4;
  localparam int unsigned LSW_SUPER = 8;
  localparam logic [15:0] LSW_RESET = 16'h0000;
  localparam logic [15:0] LSW_WMASK = 16'h011F;

  // register byte addresses
  localparam logic [3:0] ADDR_LSW = 4'h0;
  localparam logic [3:0] ADDR_RESULT = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register-to-register instruction word: opcode and function fields
  localparam logic [4:0] OPC_RR = 5'h0E;
  localparam logic [4:0] FN_CW = 5'h05;
  localparam logic [4:0] FN_AW = 5'h08;
  localparam logic [4:0] FN_SW = 5'h09;
  localparam logic [4:0] FN_ADD_WORD_WITH_CARRY_OP = 5'h0C;
  localparam logic [4:0] FN_SUBTRACT_WORD_WITH_CARRY_OP = 5'h0D;
  localparam logic [4:0] FN_ACY = 5'h1C;
  localparam logic [4:0] FN_SCY = 5'h1D;

  // decoded arithmetic operations
  typedef enum logic [2:0] {
    CIU_NOP, CIU_CW, CIU_AW, CIU_SW, CIU_ADD_WORD_WITH_CARRY_OP, CIU_SUBTRACT_WORD_WITH_CARRY_OP, CIU_ACY, CIU_SCY
  } ciu_op_t;

  // conditions; the negated form of each gives its complement
  typedef enum logic [2:0] {
    CIU_C_ZERO, CIU_C_POS, CIU_C_NEG, CIU_C_EVEN, CIU_C_ALT, CIU_C_ALE, CIU_C_LLT, CIU_C_LLE
  } ciu_cond_t;
endpackage
`default_nettype wire

/* File: hw/ciu_top.sv */
// condition indicator unit: indicators, carry chains, branch tests, supervisor bit
// assumes operand values and the instruction word come from datapath logic on aclk
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`default_nettype none
module ciu_top
  import ciu_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // arithmetic request from the datapath
  input wire logic op_valid,
  input wire logic [15:0] op_word,
  input wire logic [15:0] op_first,
  input wire logic [15:0] op_second,
  // arithmetic result to the datapath
  output logic res_valid,
  output logic res_write,
  output logic [2:0] res_reg,
  output logic [15:0] res_data,
  output logic op_illegal,
  // conditional branch or jump from the sequencer
  input wire logic br_valid,
  input wire ciu_pkg::ciu_cond_t br_cond,
  input wire logic br_not,
  output logic br_done,
  output logic br_taken,
  // interrupt events
  input wire logic io_irq,
  input wire logic [6:0] class_irq,
  // level status state
  output logic [4:0] indicators,
  output logic supervisor_state,
  output logic problem_state,
  // AXI4-Lite register slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import ciu_pkg::*;

  logic [15:0] lsw;
  ciu_op_t dec_op;
  logic [15:0] next_result;
  logic [4:0] next_ind;
  logic [15:0] opnd_a;
  logic [15:0] opnd_b;
  logic [16:0] wide;
  logic cin;
  logic chained;
  logic is_sub;
  logic cond_true;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [15:0] sw_lsw;
  logic any_irq;

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode of the register-to-register group
  always_comb
  begin
    dec_op = CIU_NOP;
    if (op_word[15:11] == OPC_RR)
    begin
      unique case (op_word[4:0])
        FN_CW: dec_op = CIU_CW;
        FN_AW: dec_op = CIU_AW;
        FN_SW: dec_op = CIU_SW;
        FN_ADD_WORD_WITH_CARRY_OP: dec_op = CIU_ADD_WORD_WITH_CARRY_OP;
        FN_SUBTRACT_WORD_WITH_CARRY_OP: dec_op = CIU_SUBTRACT_WORD_WITH_CARRY_OP;
        FN_ACY: dec_op = CIU_ACY;
        FN_SCY: dec_op = CIU_SCY;
        default: dec_op = CIU_NOP;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one adder/subtractor serves all operations, signedness left to the test
  always_comb
  begin
    chained = (dec_op == CIU_ADD_WORD_WITH_CARRY_OP) || (dec_op == CIU_SUBTRACT_WORD_WITH_CARRY_OP) || (dec_op == CIU_ACY) || (dec_op == CIU_SCY);
    is_sub = (dec_op == CIU_CW) || (dec_op == CIU_SW) || (dec_op == CIU_SUBTRACT_WORD_WITH_CARRY_OP) || (dec_op == CIU_SCY);
    cin = chained ? lsw[LSW_CARRY] : 1'b0;
    // first field is subtracted from second field
    opnd_b = op_second;
    opnd_a = ((dec_op == CIU_ACY) || (dec_op == CIU_SCY)) ? 16'h0000 : op_first;
    if (is_sub)
    begin
      wide = {1'b0, opnd_b} - {1'b0, opnd_a} - {16'h0000, cin};
    end
    else
    begin
      wide = {1'b0, opnd_b} + {1'b0, opnd_a} + {16'h0000, cin};
    end
    next_result = wide[15:0];
    // carry is borrow for subtract, carry-out for add
    next_ind[LSW_CARRY] = wide[16];
    if (is_sub)
    begin
      next_ind[LSW_OVFL] = (opnd_b[15] ^ opnd_a[15]) & (next_result[15] ^ opnd_b[15]);
    end
    else
    begin
      next_ind[LSW_OVFL] = ~(opnd_b[15] ^ opnd_a[15]) & (next_result[15] ^ opnd_b[15]);
    end
    // result indicators; chained ops keep even from the low word
    next_ind[LSW_EVEN] = chained ? lsw[LSW_EVEN] : ~next_result[0];
    next_ind[LSW_NEG] = next_result[15];
    next_ind[LSW_ZERO] = (next_result == 16'h0000) & (chained ? lsw[LSW_ZERO] : 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // result port; compare never writes an operand back
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      res_valid <= 1'b0;
      res_write <= 1'b0;
      res_reg <= 3'h0;
      res_data <= 16'h0000;
      op_illegal <= 1'b0;
    end
    else
    begin
      res_valid <= op_valid && (dec_op != CIU_NOP);
      res_write <= op_valid && (dec_op != CIU_NOP) && (dec_op != CIU_CW);
      op_illegal <= op_valid && (dec_op == CIU_NOP);
      // destination and result hold until the next decoded operation, so the result register reads back
      if (op_valid && (dec_op != CIU_NOP))
      begin
        res_reg <= op_word[7:5];
        res_data <= next_result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // condition evaluation over the current indicators
  always_comb
  begin
    unique case (br_cond)
      CIU_C_ZERO: cond_true = lsw[LSW_ZERO];
      CIU_C_POS: cond_true = ~lsw[LSW_NEG] & ~lsw[LSW_ZERO];
      CIU_C_NEG: cond_true = lsw[LSW_NEG];
      CIU_C_EVEN: cond_true = lsw[LSW_EVEN];
      CIU_C_ALT: cond_true = lsw[LSW_OVFL] ^ lsw[LSW_NEG];
      CIU_C_ALE: cond_true = (lsw[LSW_OVFL] ^ lsw[LSW_NEG]) | lsw[LSW_ZERO];
      CIU_C_LLT: cond_true = lsw[LSW_CARRY];
      CIU_C_LLE: cond_true = lsw[LSW_CARRY] | lsw[LSW_ZERO];
    endcase
  end

  // taken answer one cycle after each branch or jump request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      br_done <= 1'b0;
      br_taken <= 1'b0;
    end
    else
    begin
      br_done <= br_valid;
      br_taken <= br_valid && (cond_true ^ br_not);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level status word; interrupts win over software, operations over software
  assign any_irq = io_irq | (|class_irq);
  always_comb
  begin
    sw_lsw = lsw;
    if (do_write && (aw_addr == ADDR_LSW))
    begin
      if (w_strb[0])
      begin
        sw_lsw[7:0] = w_data[7:0];
      end
      if (w_strb[1])
      begin
        sw_lsw[15:8] = w_data[15:8];
      end
      sw_lsw = sw_lsw & LSW_WMASK;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lsw <= LSW_RESET;
    end
    else
    begin
      lsw <= sw_lsw;
      if (op_valid && (dec_op != CIU_NOP))
      begin
        lsw[4:0] <= next_ind;
      end
      if (any_irq)
      begin
        lsw[LSW_SUPER] <= 1'b1;
      end
    end
  end

  // state outputs mirror registered state through their own flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      indicators <= 5'h00;
      supervisor_state <= 1'b0;
      problem_state <= 1'b1;
    end
    else
    begin
      indicators <= lsw[4:0];
      supervisor_state <= lsw[LSW_SUPER];
      problem_state <= ~lsw[LSW_SUPER];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == ADDR_LSW) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel: data one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          ADDR_LSW: s_axi_rdata <= {16'h0000, lsw};
          ADDR_RESULT: s_axi_rdata <= {16'h0000, res_data};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence cmp_issue_s;
    op_valid && (dec_op == CIU_CW) && !any_irq;
  endsequence

  sequence chain_issue_s;
    op_valid && chained;
  endsequence

  compare_nowrite_a: assert property (cmp_issue_s |=> res_valid && !res_write)
    else $error("compare wrote a register back");

  compare_zero_a: assert property (cmp_issue_s ##0 (op_first == op_second) |=> lsw[LSW_ZERO] ##1 indicators[4])
    else $error("equal compare did not set zero");

  compare_borrow_a: assert property (cmp_issue_s ##0 (op_first > op_second) |=> lsw[LSW_CARRY])
    else $error("compare borrow not flagged as carry");

  chain_zero_a: assert property (chain_issue_s ##0 !lsw[LSW_ZERO] |=> !lsw[LSW_ZERO])
    else $error("chained zero set with nonzero earlier word");

  chain_even_a: assert property (chain_issue_s |=> lsw[LSW_EVEN] == $past(lsw[LSW_EVEN]))
    else $error("chained operation changed even");

  branch_alt_a: assert property (br_valid && !br_not && (br_cond == CIU_C_ALT) && (lsw[LSW_OVFL] != lsw[LSW_NEG])
    |=> br_done && br_taken)
    else $error("arithmetic less than not taken");

  branch_not_a: assert property (br_valid && br_not && (br_cond == CIU_C_LLT) && lsw[LSW_CARRY] |=> !br_taken)
    else $error("not form taken with condition true");

  super_set_a: assert property (any_irq |=> lsw[LSW_SUPER] ##1 supervisor_state && !problem_state)
    else $error("interrupt did not enter supervisor state");

  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
endmodule
`default_nettype wire

/* File: test/ciu_regfile.sv */
// operand register file standing in for the datapath; the bench drives op_word and the branch requests
// assumes the unit answers on aclk; the bench preloads it through ld_*
`default_nettype none
module ciu_regfile
(
  // clock
  input wire logic aclk,
  // operand selection and result write back
  input wire logic [15:0] op_word,
  output logic [15:0] op_first,
  output logic [15:0] op_second,
  input wire logic res_valid,
  input wire logic res_write,
  input wire logic [2:0] res_reg,
  input wire logic [15:0] res_data,
  // preload from the bench
  input wire logic ld_en,
  input wire logic [2:0] ld_idx,
  input wire logic [15:0] ld_val
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] regs [8];
  // first field feeds the subtrahend, second field the minuend
  assign op_first = regs[op_word[10:8]];
  assign op_second = regs[op_word[7:5]];
  // results land in the named register; a compare never writes
  always_ff @(posedge aclk)
  begin
    if (res_valid && res_write)
      regs[res_reg] <= res_data;
    else if (ld_en)
      regs[ld_idx] <= ld_val;
  end
endmodule
`default_nettype wire

/* File: test/ciu_top_tb.sv */
// self-checking bench for the condition indicator unit
// assumes ciu_pkg, ciu_top and ciu_regfile are compiled before it
`default_nettype none
module ciu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ciu_pkg::*;
  // clock, reset and ports
  logic aclk = 0, aresetn = 0, op_valid = 0, br_valid = 0, br_not = 0, io_irq = 0;
  logic [15:0] op_word = 16'h0000, op_first, op_second, res_data, ld_val = 16'h0000, last_res;
  logic res_valid, res_write, op_illegal, br_done, br_taken, supervisor_state, problem_state;
  logic [2:0] res_reg, ld_idx = 3'h0;
  logic [6:0] class_irq = 7'h00;
  logic [4:0] indicators;
  ciu_cond_t br_cond = CIU_C_ZERO;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ld_en = 0, ef_e = 0, ef_c = 0, ef_v = 0, ef_n = 0, ef_z = 0;
  logic [15:0] rf [8];
  int err_count = 0, check_count = 0, cyc = 0;

  ciu_top dut (.aclk, .aresetn, .op_valid, .op_word, .op_first, .op_second, .res_valid, .res_write,
    .res_reg, .res_data, .op_illegal, .br_valid, .br_cond, .br_not, .br_done, .br_taken, .io_irq,
    .class_irq, .indicators, .supervisor_state, .problem_state, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ciu_regfile u_rf (.aclk, .op_word, .op_first, .op_second, .res_valid, .res_write, .res_reg,
    .res_data, .ld_en, .ld_idx, .ld_val);

  ////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #10 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  // comparison and closing report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////
  // register file preload, R0 in the low word
  task automatic lda(input logic [127:0] v);
    @(posedge aclk);
    ld_en <= 1;
    for (int i = 0; i < 8; i++)
    begin
      ld_idx <= 3'(i);
      ld_val <= v[i*16 +: 16];
      rf[i] = v[i*16 +: 16];
      @(posedge aclk);
    end
    ld_en <= 0;
  endtask

  // one arithmetic operation with the expected indicator model
  task automatic do_op(input logic [4:0] fn, input logic [2:0] r1, input logic [2:0] r2);
    logic [16:0] s;
    logic [15:0] x, b;
    logic chn;
    b = rf[r2];
    x = (fn >= FN_ACY) ? 16'h0000 : rf[r1];
    chn = fn >= FN_ADD_WORD_WITH_CARRY_OP;
    s = fn[0] ? {1'b0, b} - {1'b0, x} - 17'(chn & ef_c) : {1'b0, b} + {1'b0, x} + 17'(chn & ef_c);
    ef_v = (b[15] ^ x[15] ^ !fn[0]) && (s[15] != b[15]);
    ef_c = s[16];
    ef_n = s[15];
    ef_z = (s[15:0] == 16'h0000) && (!chn || ef_z);
    ef_e = chn ? ef_e : !s[0];
    op_word <= {OPC_RR, r1, r2, fn};
    op_valid <= 1;
    @(posedge aclk);
    op_valid <= 0;
    @(posedge aclk);
    chk("res_valid", res_valid, 1);
    chk("res_write", res_write, fn != FN_CW);
    chk("res_reg", res_reg, r2);
    chk("res_data", res_data, s[15:0]);
    if (fn != FN_CW)
      rf[r2] = s[15:0];
    last_res = s[15:0];
  endtask

  task automatic chk_ind();
    tick(1);
    chk("indicators", indicators, {ef_z, ef_n, ef_v, ef_c, ef_e});
  endtask

  // every condition in plain and not form
  task automatic br_all();
    logic t;
    ciu_cond_t cd;
    for (int k = 0; k < 16; k++)
    begin
      cd = ciu_cond_t'(k[2:0]);
      br_cond <= cd;
      br_not <= k[3];
      br_valid <= 1;
      case (cd)
        CIU_C_ZERO: t = ef_z;
        CIU_C_POS: t = !ef_n && !ef_z;
        CIU_C_NEG: t = ef_n;
        CIU_C_EVEN: t = ef_e;
        CIU_C_ALT: t = ef_v ^ ef_n;
        CIU_C_ALE: t = (ef_v ^ ef_n) || ef_z;
        CIU_C_LLT: t = ef_c;
        default: t = ef_c || ef_z;
      endcase
      @(posedge aclk);
      br_valid <= 0;
      @(posedge aclk);
      chk("br_done", br_done, 1);
      chk("br_taken", br_taken, t ^ k[3]);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // register bus master
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", s_axi_rresp, er);
  endtask

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    tick(8);
    aresetn <= 1;
    tick(1);
    chk("problem", problem_state, 1);
    chk_ind();
    // compare of 2 against -5 / 65531
    lda(128'h0000_0000_0000_0002_FFFB_0000_0000_0000);
    do_op(FN_CW, 3'h3, 3'h4);
    chk_ind();
    br_all();
    // three word sum that is zero in every word
    lda(128'h0000_0001_0001_0000_FFFF_FFFE_FFFF_0000);
    do_op(FN_AW, 3'h6, 3'h3);
    do_op(FN_ADD_WORD_WITH_CARRY_OP, 3'h5, 3'h2);
    do_op(FN_ACY, 3'h0, 3'h1);
    chk_ind();
    br_all();
    // equal length sum: last word zero, low word odd
    lda(128'h0000_0002_0001_FFFF_0003_FFFF_0000_0000);
    do_op(FN_AW, 3'h6, 3'h3);
    do_op(FN_ADD_WORD_WITH_CARRY_OP, 3'h5, 3'h2);
    do_op(FN_ADD_WORD_WITH_CARRY_OP, 3'h4, 3'h1);
    chk_ind();
    br_all();
    // a register compared with itself gives a zero difference
    do_op(FN_CW, 3'h3, 3'h3);
    chk_ind();
    // subtract chain with borrow and signed overflow at the top
    lda(128'h0000_0000_0000_8000_0000_0000_0001_0000);
    do_op(FN_SW, 3'h1, 3'h2);
    do_op(FN_SCY, 3'h0, 3'h3);
    do_op(FN_SUBTRACT_WORD_WITH_CARRY_OP, 3'h5, 3'h4);
    chk_ind();
    br_all();
    // undecoded word leaves the indicators alone
    op_word <= {OPC_RR, 3'h1, 3'h2, 5'h1F};
    op_valid <= 1;
    @(posedge aclk);
    op_valid <= 0;
    @(posedge aclk);
    chk("op_illegal", op_illegal, 1);
    chk("res_valid", res_valid, 0);
    chk_ind();
    for (int i = 0; i < 8; i++)
      chk("regfile", u_rf.regs[i], rf[i]);
    // each interrupt source sets supervisor state; software clears it
    for (int i = 0; i < 8; i++)
    begin
      if (i < 7)
        class_irq <= 7'h01 << i;
      else
        io_irq <= 1;
      @(posedge aclk);
      class_irq <= 7'h00;
      io_irq <= 0;
      tick(2);
      chk("supervisor", supervisor_state, 1);
      chk("problem", problem_state, 0);
      axw(ADDR_LSW, 32'h0000_0015, RESP_OKAY);
      tick(1);
      chk("problem", problem_state, 1);
    end
    {ef_z, ef_n, ef_v, ef_c, ef_e} = 5'h15;
    chk_ind();
    br_all();
    axr(ADDR_LSW, 32'h0000_0015, RESP_OKAY);
    axw(ADDR_LSW, 32'hFFFF_FFFF, RESP_OKAY);
    axr(ADDR_LSW, {16'h0000, LSW_WMASK}, RESP_OKAY);
    axw(ADDR_RESULT, 32'h0000_1234, RESP_SLVERR);
    axr(ADDR_RESULT, {16'h0000, last_res}, RESP_OKAY);
    axr(4'h8, 32'h0000_0000, RESP_SLVERR);
    end_of_test();
  end
endmodule
`default_nettype wire
